// ### include/timer16_cfg.svh
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define CTRL_A_IDX   8'h80
`define CTRL_B_IDX   8'h81
`define COUNT_IDX    8'h84
`define CAPTURE_IDX  8'h86
`define CMP_A_IDX    8'h88
`define CMP_B_IDX    8'h8a
`define STATUS_IDX   8'h8c

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define COM_A_HI     7
`define COM_A_LO     6
`define COM_B_HI     5
`define COM_B_LO     4
`define CTRL_A_MASK  8'hf3
`define CTRL_B_MASK  8'hdf
`define EDGE_SEL_BIT 6
`define FLAG_OVF     0
`define FLAG_CMP_A   1
`define FLAG_CMP_B   2
`define FLAG_CAP     3

// ----------------------------------------
// Reset values and fixed TOP values
// ----------------------------------------
`define CTRL_RESET   8'h00
`define TOP_MAX      16'hffff
`define TOP_8BIT     16'h00ff
`define TOP_9BIT     16'h01ff
`define TOP_10BIT    16'h03ff

`endif

// ### include/timer16_pkg.sv
`default_nettype none

package timer16_pkg;

  typedef enum logic [1:0] {
    CLS_NORMAL,
    CLS_FAST,
    CLS_PHASE,
    CLS_PHASE_FREQ
  } mode_class_t;

  typedef struct packed {
    logic a;
    logic a_en;
    logic b;
    logic b_en;
  } wave_pins_t;

endpackage : timer16_pkg

`default_nettype wire

// ### logic/timer16_wave_ctrl.sv
// Contract
// - Fully synchronous; timer tick is a one-cycle enable, not a clock.
// - Phase-and-frequency-correct modes load compares at BOTTOM, never at TOP.
// - Nonzero output mode routes the channel wave output over the port pin, except code 01 where toggling is not allowed.
// - Non-PWM codes: 00 off, 01 toggle, 10 low, 11 high on match.
// - Fast PWM: 10 clear on match/set at TOP; 11 the opposite; 00 off.
// - Fast PWM code 01 toggles A only in modes 14/15; B always off.
// - Fast PWM: compare equal TOP with upper bit set ignores match.
// - Dual-slope: 10 clears on up-match, sets on down-match; 11 opposite.
// - Dual-slope code 01 toggles A only in modes 8 to 11; B off.
// - Control A bits 3:2 always read zero.
// - Mode low bits in control A 1:0, joined with upper bits.
// - Mode field picks count sequence, TOP source and waveform type.
// - Modes 0, 4, 12: immediate compare update, overflow at MAX.
// - Modes 1-3, 10, 11 phase correct; update at TOP, overflow at BOTTOM.
// - Modes 8, 9: TOP from capture or compare A; update/overflow at BOTTOM.
// - Modes 5-7, 14, 15 fast PWM; update and overflow at TOP.
// - Mode upper bits at control B 4:3; control B resets to zero.
// - Capture-defined TOP disconnects the capture input.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cfg.svh"

module timer16_wave_ctrl (
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [9:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    timer_tick_enable,
  input  wire logic                    capture_input_pin,
  output timer16_pkg::wave_pins_t      wave_pins,
  output logic                         capture_disconnected
);
  import timer16_pkg::*;

  // ----------------------------------------
  // Mode decoding
  // ----------------------------------------
  // mode class
  function automatic mode_class_t class_of(input logic [3:0] m);
    case (m)
      4'd1, 4'd2, 4'd3, 4'd10, 4'd11: class_of = CLS_PHASE;
      4'd8, 4'd9:                     class_of = CLS_PHASE_FREQ;
      4'd5, 4'd6, 4'd7, 4'd14, 4'd15: class_of = CLS_FAST;
      default:                        class_of = CLS_NORMAL;
    endcase
  endfunction : class_of

  // TOP source per mode; reserved 13 runs as normal
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmp,
                                         input logic [15:0] cap);
    case (m)
      4'd1, 4'd5:                     top_of = `TOP_8BIT;
      4'd2, 4'd6:                     top_of = `TOP_9BIT;
      4'd3, 4'd7:                     top_of = `TOP_10BIT;
      4'd4, 4'd9, 4'd11, 4'd15:       top_of = cmp;
      4'd8, 4'd10, 4'd12, 4'd14:      top_of = cap;
      default:                        top_of = `TOP_MAX;
    endcase
  endfunction : top_of

  // Next level of one wave output
  function automatic logic wave_next(input mode_class_t c, input logic [1:0] com,
                                     input logic tog_ok, input logic up, input logic m,
                                     input logic t, input logic cur);
    logic r;
    r = cur;
    case (c)
      CLS_NORMAL: begin
        if (m && com != 2'b00) r = (com == 2'b01) ? ~cur : com[0];
      end
      CLS_FAST: begin
        if (com[1]) begin
          if (m) r = com[0];
          if (t) r = ~com[0];
        end else if (com[0] && tog_ok && m) begin
          r = ~cur;
        end
      end
      CLS_PHASE, CLS_PHASE_FREQ: begin
        if (com[1]) begin
          if (m) r = up ? com[0] : ~com[0];
        end else if (com[0] && tog_ok && m) begin
          r = ~cur;
        end
      end
      default: r = cur;
    endcase
    wave_next = r;
  endfunction : wave_next

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0]  ctrl_a_r;
  logic [7:0]  ctrl_b_r;
  logic [15:0] cnt_r;
  logic [15:0] icr_r;
  logic [15:0] cmpa_buf_r;
  logic [15:0] cmpb_buf_r;
  logic [15:0] cmpa_r;
  logic [15:0] cmpb_r;
  logic        down_r;
  logic        blk_r;
  logic [3:0]  flags_r;
  logic        wave_a_r;
  logic        wave_b_r;
  logic        cap_s1_r;
  logic        cap_s2_r;
  logic        cap_s3_r;
  logic [31:0] prdata_r;

  logic [3:0]  wgm;
  mode_class_t cls;
  logic [15:0] top;
  logic [1:0]  com_a;
  logic [1:0]  com_b;
  logic        dual;
  logic        at_top;
  logic        at_bot;
  logic        at_max;
  logic        match_a;
  logic        match_b;
  logic        tog_a_ok;
  logic        cap_evt;
  logic        load_cmp;
  logic        ovf_evt;

  // mode field joined from both controls
  assign wgm   = {ctrl_b_r[4:3], ctrl_a_r[1:0]};
  assign cls   = class_of(wgm);
  assign top   = top_of(wgm, cmpa_r, icr_r);
  assign com_a = ctrl_a_r[`COM_A_HI:`COM_A_LO];
  assign com_b = ctrl_a_r[`COM_B_HI:`COM_B_LO];
  assign dual  = (cls == CLS_PHASE) || (cls == CLS_PHASE_FREQ);

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic       hit;
  logic       wr;
  logic [7:0] idx;
  logic [31:0] rd_data;

  assign idx = paddr[9:2];
  always_comb begin
    case (idx)
      `CTRL_A_IDX, `CTRL_B_IDX, `COUNT_IDX, `CAPTURE_IDX,
      `CMP_A_IDX, `CMP_B_IDX, `STATUS_IDX: hit = (paddr[1:0] == 2'b00);
      default:                             hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    case (idx)
      `CTRL_A_IDX:  rd_data[7:0]  = ctrl_a_r & `CTRL_A_MASK;
      `CTRL_B_IDX:  rd_data[7:0]  = ctrl_b_r & `CTRL_B_MASK;
      `COUNT_IDX:   rd_data[15:0] = cnt_r;
      `CAPTURE_IDX: rd_data[15:0] = icr_r;
      `CMP_A_IDX:   rd_data[15:0] = cmpa_buf_r;
      `CMP_B_IDX:   rd_data[15:0] = cmpb_buf_r;
      `STATUS_IDX:  rd_data[3:0]  = flags_r;
      default:      rd_data = 32'h0000_0000;
    endcase
  end

  assign wr      = psel && penable && pwrite && hit;
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_r;

  // Data is latched in the setup cycle so the access phase needs no wait
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata_r <= rd_data;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_a_r <= `CTRL_RESET;
      ctrl_b_r <= `CTRL_RESET;
    end else if (wr && idx == `CTRL_A_IDX) begin
      ctrl_a_r <= pwdata[7:0] & `CTRL_A_MASK;
    end else if (wr && idx == `CTRL_B_IDX) begin
      ctrl_b_r <= pwdata[7:0] & `CTRL_B_MASK;
    end
  end

  // ----------------------------------------
  // Counter and events
  // ----------------------------------------
  // events only on tick cycles; a count write blocks the next compare match
  assign at_top = timer_tick_enable && (cnt_r == top);
  assign at_bot = timer_tick_enable && (cnt_r == 16'h0000);
  assign at_max = timer_tick_enable && (cnt_r == `TOP_MAX);
  assign tog_a_ok = (cls == CLS_FAST) ? (wgm[3:1] == 3'b111) : (wgm[3:2] == 2'b10);
  // compare at TOP with upper bit set is ignored in fast PWM
  assign match_a = timer_tick_enable && !blk_r && (cnt_r == cmpa_r) &&
                   !(cls == CLS_FAST && cmpa_r == top && com_a[1]);
  assign match_b = timer_tick_enable && !blk_r && (cnt_r == cmpb_r) &&
                   !(cls == CLS_FAST && cmpb_r == top && com_b[1]);

  // tick used as enable inside the one clock domain
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r  <= 16'h0000;
      down_r <= 1'b0;
      blk_r  <= 1'b0;
    end else if (wr && idx == `COUNT_IDX) begin
      cnt_r <= pwdata[15:0];
      blk_r <= 1'b1;
    end else if (timer_tick_enable) begin
      blk_r <= 1'b0;
      if (!dual) begin
        down_r <= 1'b0;
        cnt_r  <= (cnt_r >= top) ? 16'h0000 : cnt_r + 16'h0001;
      end else if (!down_r) begin
        down_r <= (cnt_r >= top);
        cnt_r  <= (cnt_r >= top) ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
      end else begin
        down_r <= (cnt_r != 16'h0000);
        cnt_r  <= (cnt_r == 16'h0000) ? 16'h0001 : cnt_r - 16'h0001;
      end
    end
  end

  // compare load point and overflow point
  assign load_cmp = (cls == CLS_NORMAL)     ? 1'b1   :
                    (cls == CLS_PHASE_FREQ) ? at_bot : at_top;
  assign ovf_evt  = (cls == CLS_NORMAL) ? at_max :
                    (cls == CLS_FAST)   ? at_top : at_bot;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmpa_buf_r <= 16'h0000;
      cmpb_buf_r <= 16'h0000;
      icr_r      <= 16'h0000;
    end else begin
      if (wr && idx == `CMP_A_IDX) cmpa_buf_r <= pwdata[15:0];
      if (wr && idx == `CMP_B_IDX) cmpb_buf_r <= pwdata[15:0];
      if (wr && idx == `CAPTURE_IDX) icr_r <= pwdata[15:0];
      else if (cap_evt) icr_r <= cnt_r;
    end
  end

  // immediate modes follow the buffer every cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmpa_r <= 16'h0000;
      cmpb_r <= 16'h0000;
    end else if (load_cmp) begin
      cmpa_r <= cmpa_buf_r;
      cmpb_r <= cmpb_buf_r;
    end
  end

  // ----------------------------------------
  // Capture input
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cap_s1_r <= 1'b0;
      cap_s2_r <= 1'b0;
      cap_s3_r <= 1'b0;
    end else begin
      cap_s1_r <= capture_input_pin;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
    end
  end

  // capture-defined TOP cuts off the capture input
  assign capture_disconnected = (wgm == 4'd8) || (wgm == 4'd10) ||
                                (wgm == 4'd12) || (wgm == 4'd14);
  assign cap_evt = !capture_disconnected && (cap_s2_r != cap_s3_r) &&
                   (cap_s2_r == ctrl_b_r[`EDGE_SEL_BIT]);

  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) flags_r <= 4'h0;
    else begin
      flags_r <= (flags_r & ~((wr && idx == `STATUS_IDX) ? pwdata[3:0] : 4'h0)) |
                 {cap_evt, match_b, match_a, ovf_evt};
    end
  end

  // ----------------------------------------
  // Wave outputs
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end else begin
      wave_a_r <= wave_next(cls, com_a, tog_a_ok, !down_r, match_a, at_top, wave_a_r);
      wave_b_r <= wave_next(cls, com_b, 1'b0, !down_r, match_b, at_top, wave_b_r);
    end
  end

  // override; code 01 disconnects when toggling is not allowed
  assign wave_pins.a    = wave_a_r;
  assign wave_pins.b    = wave_b_r;
  assign wave_pins.a_en = (com_a != 2'b00) &&
                          !(com_a == 2'b01 && cls != CLS_NORMAL && !tog_a_ok);
  assign wave_pins.b_en = (com_b != 2'b00) && !(com_b == 2'b01 && cls != CLS_NORMAL);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_rd_ctrl_a;
    psel && !penable && !pwrite && paddr == {`CTRL_A_IDX, 2'b00} ##1 psel && penable;
  endsequence

  AST_RSV_READ: assert property (s_rd_ctrl_a |-> prdata[3:2] == 2'b00)
    else $error("reserved control bits read nonzero");
  AST_NO_TICK_HOLD: assert property (!timer_tick_enable && !wr |=> $stable(cnt_r))
    else $error("counter moved without a tick");
  AST_NO_TICK_FLAG: assert property (!timer_tick_enable && !cap_evt && !wr |=>
                                     $stable(flags_r))
    else $error("flag set without a tick");
  AST_PFC_NO_TOP_LOAD: assert property (cls == CLS_PHASE_FREQ && cnt_r != 16'h0000
                                        |=> $stable(cmpa_r))
    else $error("compare loaded away from bottom");
  AST_OVERRIDE_A: assert property (com_a[1] |-> wave_pins.a_en)
    else $error("channel a not routed");
  AST_NORMAL_SET: assert property (cls == CLS_NORMAL && com_a == 2'b11 && match_a
                                   |=> wave_pins.a)
    else $error("normal set on match failed");
  AST_FAST_TOP: assert property (cls == CLS_FAST && com_a == 2'b10 && at_top
                                 |=> wave_pins.a)
    else $error("fast pwm top set failed");
  AST_B_TOGGLE_OFF: assert property (com_b == 2'b01 && cls != CLS_NORMAL
                                     |-> !wave_pins.b_en)
    else $error("channel b toggle connected in pwm");
  AST_DUAL_UP_CLEAR: assert property (dual && com_a == 2'b10 && match_a && !down_r
                                      |=> !wave_pins.a)
    else $error("dual slope up match did not clear");
  AST_CAP_OFF: assert property (capture_disconnected && !wr |=> $stable(icr_r))
    else $error("capture taken while disconnected");

endmodule : timer16_wave_ctrl

`default_nettype wire

// ### verif/test_timer16_wave_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cfg.svh"

module test_timer16_wave_ctrl;
  import timer16_pkg::*;

  typedef struct packed {
    logic        wave;
    logic [32:0] exp;
    logic [32:0] mask;
  } note_t;

  logic        mclk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tick;
  logic        cap_pin;
  logic        probe;
  logic        cap_disc;
  wave_pins_t  wave_pins;
  note_t       notes[$];
  note_t       nt;
  logic [32:0] seen;
  int          num_errors;
  int          samples_checked;
  integer      seed;
  logic [31:0] rnd;
  logic [7:0]  ctl;
  logic [4:0]  exp_pins;

  timer16_wave_ctrl u_timer16_wave_ctrl (
    .mclk                 (mclk),
    .rst_b                (rst_b),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .timer_tick_enable    (tick),
    .capture_input_pin    (cap_pin),
    .wave_pins            (wave_pins),
    .capture_disconnected (cap_disc)
  );

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("Error watchdog expected done seen hang");
    end_sim();
  end

  // ----------------------------------------
  // Bus and timer drivers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic err, input logic [31:0] d);
    notes.push_back('{1'b0, {err, d}, {33{1'b1}}});
    apb(1'b0, idx, 32'h0);
  endtask : rd

  task automatic ticks(input int n);
    @(posedge mclk);
    tick <= 1'b1;
    repeat (n) @(posedge mclk);
    tick <= 1'b0;
  endtask : ticks

  // Pins as {capture off, a, a_en, b, b_en}
  task automatic pins(input logic [4:0] e, input logic [4:0] m);
    repeat (2) @(posedge mclk);
    notes.push_back('{1'b1, {28'h0, e}, {28'h0, m}});
    probe <= 1'b1;
    @(posedge mclk);
    probe <= 1'b0;
  endtask : pins

  task automatic run(input logic [7:0] ca, input logic [15:0] cnt, input int n);
    wr(`CTRL_A_IDX, {24'h0, ca});
    wr(`COUNT_IDX, {16'h0, cnt});
    ticks(n);
  endtask : run

  function automatic logic conn(input logic [3:0] m, input logic [1:0] c, input logic ch_a);
    if (c == 2'b00) return 1'b0;
    if (c != 2'b01) return 1'b1;
    if (!(m inside {4'd1, 4'd2, 4'd3, 4'd5, 4'd6, 4'd7, [4'd8:4'd11], 4'd14, 4'd15}))
      return 1'b1;
    return ch_a && (m inside {[4'd8:4'd11], 4'd14, 4'd15});
  endfunction : conn

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge mclk) begin
    if ((psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
        || probe === 1'b1) begin
      seen = probe ? {28'h0, cap_disc, wave_pins} : {pslverr, prdata};
      samples_checked++;
      if (notes.size() == 0) begin
        num_errors++;
        $display("Error queue expected note seen none");
      end else begin
        nt = notes.pop_front();
        if ((seen & nt.mask) !== (nt.exp & nt.mask)) begin
          num_errors++;
          $display("Error %s expected %h seen %h", nt.wave ? "pins" : "apb", nt.exp, seen);
        end
      end
    end
  end

  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed    = 63107;
    rst_b   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 10'h000;
    pwdata  = 32'h0;
    tick    = 1'b0;
    cap_pin = 1'b0;
    probe   = 1'b0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`CTRL_A_IDX, 1'b0, 32'h0);
    rd(`CTRL_B_IDX, 1'b0, 32'h0);
    wr(`CTRL_A_IDX, 32'hff);
    rd(`CTRL_A_IDX, 1'b0, 32'hf3);
    wr(`CTRL_B_IDX, 32'hff);
    rd(`CTRL_B_IDX, 1'b0, 32'hdf);
    wr(`CTRL_B_IDX, 32'h0);
    rd(8'hff, 1'b1, 32'h0);
    repeat (3) begin
      rnd = $random(seed);
      wr(`CAPTURE_IDX, rnd);
      rd(`CAPTURE_IDX, 1'b0, {16'h0, rnd[15:0]});
    end
    // Normal mode: set, toggle+low, toggle, low+high
    wr(`CTRL_A_IDX, 32'h0);
    wr(`CMP_A_IDX, 32'h10);
    wr(`CMP_B_IDX, 32'h10);
    run(8'hf0, 16'h000f, 3);
    pins(5'b01111, 5'b11111);
    run(8'h60, 16'h000f, 3);
    pins(5'b00101, 5'b11111);
    run(8'h50, 16'h000f, 3);
    pins(5'b01111, 5'b11111);
    run(8'hb0, 16'h000f, 3);
    pins(5'b00111, 5'b11111);
    // Fast PWM 8-bit: TOP action then match action
    wr(`CTRL_B_IDX, 32'h08);
    run(8'hb1, 16'h00fe, 3);
    pins(5'b01101, 5'b11111);
    ticks(17);
    pins(5'b00111, 5'b11111);
    // Phase correct 8-bit: up match then down match
    wr(`CTRL_B_IDX, 32'h00);
    run(8'he1, 16'h000e, 4);
    pins(5'b01101, 5'b11111);
    run(8'he1, 16'h00fe, 245);
    pins(5'b00111, 5'b11111);
    run(8'hb1, 16'h00fe, 245);
    pins(5'b01101, 5'b11111);
    run(8'hb1, 16'h0002, 20);
    pins(5'b00111, 5'b11111);
    // Capture: rising edge copies the count unless capture sets TOP
    wr(`CTRL_A_IDX, 32'h0);
    wr(`STATUS_IDX, 32'hf);
    wr(`CTRL_B_IDX, 32'h40);
    wr(`COUNT_IDX, 32'h1234);
    cap_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`CAPTURE_IDX, 1'b0, 32'h1234);
    rd(`STATUS_IDX, 1'b0, 32'h8);
    wr(`CTRL_B_IDX, 32'h58);
    wr(`COUNT_IDX, 32'h0055);
    cap_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    cap_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`CAPTURE_IDX, 1'b0, 32'h1234);
    // Every mode with every output code
    for (int m = 0; m < 16; m++) begin
      for (int c = 0; c < 4; c++) begin
        ctl = {c[1:0], c[1:0], 2'b00, m[1:0]};
        wr(`CTRL_B_IDX, {27'h0, m[3:2], 3'b000});
        wr(`CTRL_A_IDX, {24'h0, ctl});
        exp_pins = {m[3:0] inside {4'd8, 4'd10, 4'd12, 4'd14}, 1'b0,
                    conn(m[3:0], c[1:0], 1'b1), 1'b0, conn(m[3:0], c[1:0], 1'b0)};
        pins(exp_pins, 5'b10101);
      end
    end
    repeat (3) @(posedge mclk);
    end_sim();
  end

endmodule : test_timer16_wave_ctrl

`default_nettype wire
